//--- inc/srw_defines.svh
// Purpose: constants for the reset and watchdog block
// Assumes: 32-bit AHB-Lite register words
// Notes: offsets are byte addresses
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH
`define SRW_OFF_CTRL     12'h000
`define SRW_OFF_PRESC    12'h004
`define SRW_OFF_RELOAD   12'h008
`define SRW_OFF_COUNT    12'h00C
`define SRW_OFF_KICK     12'h010
`define SRW_OFF_DROP     12'h014
`define SRW_OFF_STATUS   12'h018
`define SRW_OFF_MASK     12'h01C
`define SRW_OFF_CAUSE    12'h020
`define SRW_OFF_BOOT     12'h024
`define SRW_BOOT_ADDR    32'h0000_0000
`define SRW_TERMINAL     16'h0000
`define SRW_RELOAD_RST   16'hFFFF
`define SRW_PRESC_RST    8'h00
`define SRW_KICK_KEY     32'h0000_5A5A
`define SRW_CTRL_EN      0
`define SRW_CTRL_WDMODE  1
`define SRW_DROP_IOMASK  0
`define SRW_DROP_OFF     1
`define SRW_ST_TC        0
`define SRW_ST_IODROP    1
`define SRW_CS_CORE      0
`define SRW_CS_IO        1
`define SRW_CS_PIN       2
`define SRW_CS_JTAG      3
`define SRW_CS_WDOG      4
`define SRW_POR_NS       100000
`define SRW_PIN_NS       1000
`define SRW_CLK_NS       100
`endif

//--- inc/srw_pkg.sv
// Purpose: types for the reset and watchdog block
// Assumes: nothing
// Notes: reset sequencer states
package srw_pkg;
	typedef enum logic [1:0] {SRW_WAIT_SUPPLY, SRW_HOLD, SRW_RUN} srw_state_t;
endpackage : srw_pkg

//--- core/srw_sync.sv
// Purpose: two-flop synchroniser for one level
// Assumes: reset value given by parameter
// Notes: first flop read only by second
`timescale 1ns/10ps
module srw_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic din,
	output logic      dout
);
	logic meta_q;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_q <= RESET_VAL;
			dout   <= RESET_VAL;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : srw_sync

//--- core/srw_wdog.sv
// Purpose: watchdog / free-running down-counter with prescaler
// Assumes: single clock, enable cleared by system reset
// Notes: tcPulse one cycle when count reaches terminal
`timescale 1ns/10ps
`include "srw_defines.svh"
module srw_wdog #(
	parameter int CW = 16,
	parameter int PW = 8
) (
	input  wire logic          clk,
	input  wire logic          rstN,
	input  wire logic          enable,
	input  wire logic [PW-1:0] presc,
	input  wire logic [CW-1:0] reloadVal,
	input  wire logic          reload,
	output logic [CW-1:0]      count_q,
	output logic               tcPulse
);
	logic [PW-1:0] pre_q;
	logic          tick;

	assign tick = enable && (pre_q == presc);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pre_q <= '0;
		end else if (!enable || tick || reload) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			count_q <= `SRW_RELOAD_RST;
		end else if (reload) begin
			count_q <= reloadVal;
		end else if (tick) begin
			count_q <= (count_q == `SRW_TERMINAL) ? reloadVal : count_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			tcPulse <= 1'b0;
		end else begin
			tcPulse <= tick && !reload && (count_q == `SRW_TERMINAL + 16'h0001);
		end
	end
endmodule : srw_wdog

//--- core/srw_reset_ctrl.sv
// Purpose: reset source gathering, sequencing, watchdog and AHB-Lite registers
// Assumes: clk 10 MHz; detector and pin inputs asynchronous
// Notes: sysRstN is the internal reset; cause register survives it
`timescale 1ns/10ps
`include "srw_defines.svh"
module srw_reset_ctrl
	import srw_pkg::*;
#(
	parameter int POR_CYCLES = (`SRW_POR_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS,
	parameter int PIN_CYCLES = (`SRW_PIN_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS,
	parameter int CW         = 16,
	parameter int PW         = 8
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        coreSupplyOk,
	input  wire logic        ioSupplyOkLow,
	input  wire logic        ioSupplyOkHigh,
	input  wire logic        ioRangeHigh,
	input  wire logic        board_reset_request_low,
	input  wire logic        debugMode,
	input  wire logic        jtagResetCmd,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq,
	output logic             sysRstN,
	output logic             board_reset_drive_low,
	output logic [31:0]      bootAddr
);
	localparam int TW = (POR_CYCLES > PIN_CYCLES ? $clog2(POR_CYCLES + 1)
	                                              : $clog2(PIN_CYCLES + 1));

	logic            rstMeta_q, rstN_q;
	logic            coreOk, ioOkLow, ioOkHigh, reqLow, dbg, jtagCmd;
	logic            ioSupplyOk;
	logic            ioRange_q;
	logic            ioRangeSync;
	srw_state_t      state_q;
	logic [TW-1:0]   porCnt_q, pinCnt_q;
	logic            pinFire, jtagFire, wdogFire, coreFire, ioFire, anyFire;
	logic            jtagPrev_q;
	logic            ctrlEn_q, ctrlMode_q;
	logic [PW-1:0]   presc_q;
	logic [CW-1:0]   reload_q;
	logic            dropIoMask_q, dropOff_q;
	logic [1:0]      status_q, mask_q;
	logic [4:0]      cause_q;
	logic [CW-1:0]   count;
	logic            tcPulse, kick;
	logic            aValid_q, aWrite_q;
	logic [11:0]     aAddr_q;
	logic            aPhase, wr;

	// Reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstN_q    <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN_q    <= rstMeta_q;
		end
	end

	srw_sync #(.RESET_VAL(1'b0)) uCore (.clk(clk), .rstN(rstN_q), .din(coreSupplyOk),
		.dout(coreOk));
	srw_sync #(.RESET_VAL(1'b0)) uIoL (.clk(clk), .rstN(rstN_q), .din(ioSupplyOkLow),
		.dout(ioOkLow));
	srw_sync #(.RESET_VAL(1'b0)) uIoH (.clk(clk), .rstN(rstN_q), .din(ioSupplyOkHigh),
		.dout(ioOkHigh));
	srw_sync #(.RESET_VAL(1'b1)) uPin (.clk(clk), .rstN(rstN_q),
		.din(board_reset_request_low), .dout(reqLow));
	srw_sync #(.RESET_VAL(1'b0)) uDbg (.clk(clk), .rstN(rstN_q), .din(debugMode),
		.dout(dbg));
	srw_sync #(.RESET_VAL(1'b0)) uJtag (.clk(clk), .rstN(rstN_q), .din(jtagResetCmd),
		.dout(jtagCmd));
	srw_sync #(.RESET_VAL(1'b0)) uRng (.clk(clk), .rstN(rstN_q), .din(ioRangeHigh),
		.dout(ioRangeSync));

	// Non-volatile range setting caught after release
	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			ioRange_q <= 1'b0;
		end else if (state_q == SRW_WAIT_SUPPLY) begin
			ioRange_q <= ioRangeSync;
		end
	end

	assign ioSupplyOk = ioRange_q ? ioOkHigh : ioOkLow;

	assign coreFire = !coreOk;
	assign ioFire   = !ioSupplyOk && !dropOff_q && !dropIoMask_q;

	// Request pin width filter
	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			pinCnt_q <= '0;
		end else if (reqLow) begin
			pinCnt_q <= '0;
		end else if (pinCnt_q != TW'(PIN_CYCLES)) begin
			pinCnt_q <= pinCnt_q + 1'b1;
		end
	end
	assign pinFire = (pinCnt_q == TW'(PIN_CYCLES)) && !reqLow;

	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			jtagPrev_q <= 1'b0;
		end else begin
			jtagPrev_q <= jtagCmd;
		end
	end
	assign jtagFire = dbg && jtagCmd && !jtagPrev_q;

	assign wdogFire = tcPulse && ctrlMode_q && ctrlEn_q;
	assign anyFire  = coreFire || ioFire || pinFire || jtagFire || wdogFire;

	// Reset sequencer
	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			state_q  <= SRW_WAIT_SUPPLY;
			porCnt_q <= '0;
		end else begin
			unique case (state_q)
				SRW_WAIT_SUPPLY: begin
					porCnt_q <= '0;
					if (coreOk && ioSupplyOk) begin
						state_q <= SRW_HOLD;
					end
				end
				SRW_HOLD: begin
					if (!coreOk || !ioSupplyOk) begin
						state_q <= SRW_WAIT_SUPPLY;
					end else if (porCnt_q == TW'(POR_CYCLES - 1)) begin
						state_q <= SRW_RUN;
					end else begin
						porCnt_q <= porCnt_q + 1'b1;
					end
				end
				SRW_RUN: begin
					if (coreFire || ioFire) begin
						state_q <= SRW_WAIT_SUPPLY;
					end else if (anyFire) begin
						state_q  <= SRW_HOLD;
						porCnt_q <= '0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			sysRstN               <= 1'b0;
			board_reset_drive_low <= 1'b0;
		end else begin
			sysRstN               <= (state_q == SRW_RUN) && !anyFire;
			board_reset_drive_low <= (state_q == SRW_RUN) && !anyFire;
		end
	end

	assign bootAddr = `SRW_BOOT_ADDR;

	// AHB-Lite slave, zero wait states
	assign aPhase    = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr        = aValid_q && aWrite_q;
	assign kick      = wr && (aAddr_q == `SRW_OFF_KICK) && (hwdata == `SRW_KICK_KEY);

	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			aValid_q <= 1'b0;
			aWrite_q <= 1'b0;
			aAddr_q  <= '0;
		end else if (hready) begin
			aValid_q <= aPhase;
			aWrite_q <= hwrite;
			aAddr_q  <= {haddr[11:2], 2'b00};
		end
	end

	// Control registers loaded with reset values by internal reset (reload_q to FFFF)
	always_ff @(posedge clk or negedge sysRstN) begin
		if (!sysRstN) begin
			ctrlEn_q     <= 1'b0;
			ctrlMode_q   <= 1'b0;
			presc_q      <= `SRW_PRESC_RST;
			reload_q     <= `SRW_RELOAD_RST;
			dropIoMask_q <= 1'b0;
			dropOff_q    <= 1'b0;
			mask_q       <= '0;
		end else if (wr) begin
			unique case (aAddr_q)
				`SRW_OFF_CTRL: begin
					ctrlEn_q   <= hwdata[`SRW_CTRL_EN];
					ctrlMode_q <= hwdata[`SRW_CTRL_WDMODE];
				end
				`SRW_OFF_PRESC:  presc_q <= hwdata[PW-1:0];
				`SRW_OFF_RELOAD: reload_q <= hwdata[CW-1:0];
				`SRW_OFF_DROP: begin
					dropIoMask_q <= hwdata[`SRW_DROP_IOMASK];
					dropOff_q    <= hwdata[`SRW_DROP_OFF];
				end
				`SRW_OFF_MASK:   mask_q <= hwdata[1:0];
				default: begin
				end
			endcase
		end
	end

	// Sticky events, set beats clear
	always_ff @(posedge clk or negedge sysRstN) begin
		if (!sysRstN) begin
			status_q <= '0;
		end else begin
			status_q[`SRW_ST_TC] <= (tcPulse && ctrlEn_q) || (status_q[`SRW_ST_TC] &&
				!(wr && aAddr_q == `SRW_OFF_STATUS && hwdata[`SRW_ST_TC]));
			status_q[`SRW_ST_IODROP] <= (!ioSupplyOk && dropIoMask_q && !dropOff_q) ||
				(status_q[`SRW_ST_IODROP] &&
				!(wr && aAddr_q == `SRW_OFF_STATUS && hwdata[`SRW_ST_IODROP]));
		end
	end

	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	// Cause of the last reset, survives internal reset
	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			cause_q <= '0;
		end else if (anyFire && state_q == SRW_RUN) begin
			cause_q <= {wdogFire, jtagFire, pinFire, ioFire, coreFire};
		end
	end

	srw_wdog #(.CW(CW), .PW(PW)) uWdog (
		.clk       (clk),
		.rstN      (sysRstN),
		.enable    (ctrlEn_q),
		.presc     (presc_q),
		.reloadVal (reload_q),
		.reload    (kick),
		.count_q   (count),
		.tcPulse   (tcPulse)
	);

	// Read data registered in data phase
	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			hrdata <= '0;
		end else if (aPhase && !hwrite) begin
			unique case ({haddr[11:2], 2'b00})
				`SRW_OFF_CTRL:   hrdata <= {30'h0, ctrlMode_q, ctrlEn_q};
				`SRW_OFF_PRESC:  hrdata <= {{(32-PW){1'b0}}, presc_q};
				`SRW_OFF_RELOAD: hrdata <= {{(32-CW){1'b0}}, reload_q};
				`SRW_OFF_COUNT:  hrdata <= {{(32-CW){1'b0}}, count};
				`SRW_OFF_DROP:   hrdata <= {30'h0, dropOff_q, dropIoMask_q};
				`SRW_OFF_STATUS: hrdata <= {30'h0, status_q};
				`SRW_OFF_MASK:   hrdata <= {30'h0, mask_q};
				`SRW_OFF_CAUSE:  hrdata <= {27'h0, cause_q};
				`SRW_OFF_BOOT:   hrdata <= `SRW_BOOT_ADDR;
				default:         hrdata <= '0;
			endcase
		end
	end
endmodule : srw_reset_ctrl

//--- bench/srw_reset_ctrl_checker.sv
// Purpose: port checks for the reset controller
// Assumes: one clock, rst_n async active low
// Notes: bound from the bench top
`timescale 1ns/10ps
module srw_reset_ctrl_checker #(
	parameter int POR_CYCLES = 8,
	parameter int PIN_CYCLES = 3
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        coreSupplyOk,
	input wire logic        board_reset_request_low,
	input wire logic        debugMode,
	input wire logic        jtagResetCmd,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irq,
	input wire logic        sysRstN,
	input wire logic        board_reset_drive_low,
	input wire logic [31:0] bootAddr
);
	logic [7:0] lowCnt_q;
	logic [7:0] pinCnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Run lengths of internal reset and of a low request pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) lowCnt_q <= 8'h00;
		else if (sysRstN) lowCnt_q <= 8'h00;
		else if (lowCnt_q != 8'hFF) lowCnt_q <= lowCnt_q + 8'h01;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) pinCnt_q <= 8'h00;
		else if (board_reset_request_low) pinCnt_q <= 8'h00;
		else if (pinCnt_q != 8'hFF) pinCnt_q <= pinCnt_q + 8'h01;
	end
	boot_fixed_a: assert property (bootAddr == 32'h0000_0000)
		else $error("boot address moved");
	board_mirror_a: assert property (board_reset_drive_low == sysRstN)
		else $error("board reset differs from internal reset");
	core_drop_a: assert property (!coreSupplyOk [*4] |-> ##[0:3] !sysRstN)
		else $error("core dropout without reset");
	pin_reset_a: assert property (pinCnt_q >= PIN_CYCLES + 5 |-> !sysRstN)
		else $error("long request pulse without reset");
	por_length_a: assert property ($rose(sysRstN) |-> lowCnt_q >= POR_CYCLES)
		else $error("reset released too early");
	irq_reset_a: assert property (!sysRstN [*3] |-> !irq)
		else $error("interrupt survives reset");
	jtag_reset_a: assert property (debugMode [*4] ##1 $rose(jtagResetCmd) |-> ##[1:8] !sysRstN)
		else $error("debug reset command ignored");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	cover property ($fell(sysRstN));
	cover property ($rose(irq));
	cover property (debugMode && $rose(jtagResetCmd));
endmodule : srw_reset_ctrl_checker

//--- bench/srw_board_model.sv
// Purpose: board reset circuitry, supplies and debug controller
// Assumes: driven just after rising clk edges
// Notes: request pin is open drain with a board pull-up
`timescale 1ns/10ps
module srw_board_model (
	input  wire logic clk,
	output logic      coreSupplyOk,
	output logic      ioSupplyOkLow,
	output logic      ioSupplyOkHigh,
	output logic      ioRangeHigh,
	output logic      board_reset_request_low,
	output logic      debugMode,
	output logic      jtagResetCmd
);
	logic buttonDown = 1'b0;
	// Pull-up on the board; only the button pulls low
	assign board_reset_request_low = buttonDown ? 1'b0 : 1'b1;
	initial begin
		coreSupplyOk = 1'b0;
		ioSupplyOkLow = 1'b1;
		ioSupplyOkHigh = 1'b1;
		ioRangeHigh = 1'b0;
		debugMode = 1'b0;
		jtagResetCmd = 1'b0;
	end
	task automatic setSupply(input logic c, input logic lo, input logic hi);
		@(posedge clk);
		coreSupplyOk <= c;
		ioSupplyOkLow <= lo;
		ioSupplyOkHigh <= hi;
	endtask : setSupply
	task automatic dip(input logic c, input logic lo, input logic hi);
		setSupply(c, lo, hi);
		repeat (12) @(posedge clk);
		setSupply(1'b1, 1'b1, 1'b1);
	endtask : dip
	task automatic press(input int n);
		@(posedge clk);
		buttonDown <= 1'b1;
		repeat (n) @(posedge clk);
		buttonDown <= 1'b0;
	endtask : press
	task automatic jtagReset(input logic d);
		@(posedge clk);
		debugMode <= d;
		repeat (4) @(posedge clk);
		jtagResetCmd <= 1'b1;
		repeat (6) @(posedge clk);
		jtagResetCmd <= 1'b0;
		debugMode <= 1'b0;
	endtask : jtagReset
	task automatic setRange(input logic r);
		@(posedge clk);
		ioRangeHigh <= r;
	endtask : setRange
endmodule : srw_board_model

//--- bench/system_reset_and_watchdog_tb.sv
// Purpose: self-checking bench for the reset and watchdog block
// Assumes: short reset counts for simulation
// Notes: board side comes from srw_board_model
`timescale 1ns/10ps
`include "srw_defines.svh"
module system_reset_and_watchdog_tb;
	localparam int POR = 8;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, bootAddr;
	logic        hreadyout, hresp, irq, sysRstN, board_reset_drive_low;
	logic        coreSupplyOk, ioSupplyOkLow, ioSupplyOkHigh, ioRangeHigh;
	logic        board_reset_request_low, debugMode, jtagResetCmd;
	int          fail_count = 0;
	int          checks = 0;
	always #50 clk = ~clk;
	srw_board_model u_srw_board_model (.clk, .coreSupplyOk, .ioSupplyOkLow, .ioSupplyOkHigh,
		.ioRangeHigh, .board_reset_request_low, .debugMode, .jtagResetCmd);
	srw_reset_ctrl #(.POR_CYCLES(POR), .PIN_CYCLES(3)) u_srw_reset_ctrl (.clk, .rst_n,
		.coreSupplyOk, .ioSupplyOkLow, .ioSupplyOkHigh, .ioRangeHigh, .board_reset_request_low,
		.debugMode, .jtagResetCmd, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .sysRstN,
		.board_reset_drive_low, .bootAddr);
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {20'h00000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rdChk(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		chk(n, r, e);
	endtask : rdChk
	task automatic bitChk(input string n, input logic [11:0] a, input int b);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		chk(n, 32'(r[b]), 32'h1);
	endtask : bitChk
	task automatic waitRst(input logic lvl, input int n);
		repeat (n) if (sysRstN !== lvl) @(posedge clk);
		chk("sysRstN", 32'(sysRstN), 32'(lvl));
	endtask : waitRst
	task automatic settle(input logic [31:0] e);
		chk("sysRstN", 32'(sysRstN), e);
		waitRst(1'b1, 200);
	endtask : settle
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clk);
			chk("sysRstN", 32'(sysRstN), 32'h1);
		end
	endtask : quiet
	task automatic tPower();
		int n;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			chk("heldLow", 32'(sysRstN), 32'h0);
		end
		u_srw_board_model.setSupply(1'b1, 1'b1, 1'b1);
		n = 0;
		while (sysRstN !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("porLen", 32'(n > POR && n < 100), 32'h1);
	endtask : tPower
	task automatic tRegs();
		rdChk("ctrl", `SRW_OFF_CTRL, 32'h0000_0000);
		rdChk("reload", `SRW_OFF_RELOAD, 32'h0000_FFFF);
		rdChk("boot", `SRW_OFF_BOOT, 32'h0000_0000);
		wr(`SRW_OFF_PRESC, 32'h0000_01FF);
		rdChk("presc", `SRW_OFF_PRESC, 32'h0000_00FF);
		wr(12'h040, 32'hFFFF_FFFF);
		rdChk("unmapped", 12'h040, 32'h0000_0000);
	endtask : tRegs
	task automatic tTimer();
		logic [31:0] r;
		wr(`SRW_OFF_RELOAD, 32'h0000_0004);
		wr(`SRW_OFF_PRESC, 32'h0000_0001);
		wr(`SRW_OFF_MASK, 32'h0000_0001);
		wr(`SRW_OFF_CTRL, 32'h0000_0001);
		wr(`SRW_OFF_KICK, `SRW_KICK_KEY);
		bus(1'b0, `SRW_OFF_COUNT, 32'h0000_0000, r);
		chk("count", 32'(r <= 32'h0000_0004), 32'h1);
		quiet(30);
		chk("irq", 32'(irq), 32'h1);
		wr(`SRW_OFF_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk("irqMasked", 32'(irq), 32'h0);
		wr(`SRW_OFF_CTRL, 32'h0000_0000);
		wr(`SRW_OFF_STATUS, 32'h0000_0001);
		wr(`SRW_OFF_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irqCleared", 32'(irq), 32'h0);
	endtask : tTimer
	task automatic tPin();
		u_srw_board_model.press(2);
		settle(32'h1);
		u_srw_board_model.press(12);
		settle(32'h0);
		bitChk("causePin", `SRW_OFF_CAUSE, `SRW_CS_PIN);
	endtask : tPin
	task automatic tWdog();
		wr(`SRW_OFF_RELOAD, 32'h0000_0020);
		wr(`SRW_OFF_CTRL, 32'h0000_0003);
		repeat (4) begin
			wr(`SRW_OFF_KICK, `SRW_KICK_KEY);
			quiet(12);
		end
		wr(`SRW_OFF_KICK, 32'h0000_1234);
		waitRst(1'b0, 100);
		waitRst(1'b1, 200);
		bitChk("causeWdog", `SRW_OFF_CAUSE, `SRW_CS_WDOG);
		rdChk("ctrlOff", `SRW_OFF_CTRL, 32'h0000_0000);
	endtask : tWdog
	task automatic tJtag();
		u_srw_board_model.jtagReset(1'b0);
		settle(32'h1);
		u_srw_board_model.jtagReset(1'b1);
		settle(32'h0);
		bitChk("causeJtag", `SRW_OFF_CAUSE, `SRW_CS_JTAG);
	endtask : tJtag
	task automatic tDrop();
		u_srw_board_model.dip(1'b1, 1'b1, 1'b0);
		settle(32'h1);
		u_srw_board_model.dip(1'b1, 1'b0, 1'b0);
		settle(32'h0);
		bitChk("causeIo", `SRW_OFF_CAUSE, `SRW_CS_IO);
		wr(`SRW_OFF_DROP, 32'h0000_0001);
		u_srw_board_model.dip(1'b1, 1'b0, 1'b0);
		settle(32'h1);
		bitChk("ioSeen", `SRW_OFF_STATUS, `SRW_ST_IODROP);
		wr(`SRW_OFF_DROP, 32'h0000_0002);
		u_srw_board_model.dip(1'b1, 1'b0, 1'b0);
		settle(32'h1);
		u_srw_board_model.dip(1'b0, 1'b1, 1'b1);
		settle(32'h0);
		bitChk("causeCore", `SRW_OFF_CAUSE, `SRW_CS_CORE);
		u_srw_board_model.setRange(1'b1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		waitRst(1'b1, 200);
		u_srw_board_model.dip(1'b1, 1'b1, 1'b0);
		settle(32'h0);
	endtask : tDrop
	initial begin
		#(5000 * 100);
		fail_count++;
		stop_test();
	end
	initial begin
		tPower();
		tRegs();
		tTimer();
		tPin();
		tWdog();
		tJtag();
		tDrop();
		stop_test();
	end
endmodule : system_reset_and_watchdog_tb
bind srw_reset_ctrl srw_reset_ctrl_checker #(.POR_CYCLES(POR_CYCLES), .PIN_CYCLES(PIN_CYCLES))
	u_srw_reset_ctrl_checker (.clk, .rst_n, .coreSupplyOk, .board_reset_request_low, .debugMode,
	.jtagResetCmd, .hreadyout, .hresp, .irq, .sysRstN, .board_reset_drive_low, .bootAddr);
